// file: hdl/spi_ctrl_data_status.sv
// Purpose: control, data and status part of a synchronous serial controller
// Assumes: aclk at 10 MHz, slave serial clock at most aclk/12, mode 0 framing
// Notes:   select and data pins pass two flip-flops, serial clock three; status register is read only
// Functional notes
// - loopback feeds serial output back as input
// - controller idle while enable bit clear
// - role bit writable only while disabled
// - role zero: master drives clock, mosi, select
// - role one: slave drives only miso
// - output disable stops miso drive in slave
// - word starts at once when idle in master role, on select in slave role, else queued
// - data read pops oldest received frame
// - short received frames read right-justified, zero-filled
// - status bit0 transmit empty, resets one
// - status bit1 transmit not full, resets one
// - status bit2 receive not empty, resets zero
// - status bit3 receive full, resets zero
// - status bit4 busy while shifting or queued
// - size field codes three..fifteen give 4..16 bits
// - slave works up to aclk over twelve
//
// Implementation choice: the AXI4-Lite register port.
module spi_ctrl_data_status
  import spi_ctrl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        ssel_n_in,
  output logic             ssel_n_out,
  output logic             ssel_n_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe
);

  function automatic logic [PTR_W:0] ptr_inc(input logic [PTR_W:0] p);
    ptr_inc = p + 1'b1;
  endfunction

  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] r);
    addr_is = (a[11:0] & ADDR_MASK) == (r[11:0] & ADDR_MASK);
  endfunction

  logic                  loopback_select_reg;
  logic                  controller_enable_reg;
  logic                  role_select_reg;
  logic                  slave_output_disable_reg;
  logic [3:0]            frame_size_field_reg;
  logic [7:0]            clk_div_reg;
  logic [WORD_W-1:0]     tx_mem [FIFO_DEPTH];
  logic [WORD_W-1:0]     rx_mem [FIFO_DEPTH];
  logic [PTR_W:0]        tx_wr_reg;
  logic [PTR_W:0]        tx_rd_reg;
  logic [PTR_W:0]        rx_wr_reg;
  logic [PTR_W:0]        rx_rd_reg;
  logic                  tx_fifo_empty;
  logic                  tx_fifo_full;
  logic                  rx_fifo_empty;
  logic                  rx_fifo_full;
  logic                  aw_hold_reg;
  logic                  w_hold_reg;
  logic [31:0]           aw_addr_reg;
  logic [31:0]           w_data_reg;
  logic                  w_strb0_reg;
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  tx_push;
  logic                  rx_pop;
  shift_state_t          sh_state_reg;
  logic [WORD_W-1:0]     tx_shift_reg;
  logic [WORD_W-1:0]     rx_shift_reg;
  logic [4:0]            bit_cnt_reg;
  logic [4:0]            frame_bits;
  logic [7:0]            div_cnt_reg;
  logic                  tick;
  logic                  frame_done;
  logic                  tx_pop;
  logic [2:0]            sclk_sync_reg;
  logic [1:0]            ssel_sync_reg;
  logic [1:0]            mosi_sync_reg;
  logic [1:0]            miso_sync_reg;
  logic                  ser_out;
  logic                  ser_in;
  logic                  slv_rise;
  logic                  slv_fall;
  logic                  slv_sel;
  logic                  slv_sel_d_reg;
  logic                  busy_flag;
  logic                  master_sclk_reg;

  ////////////////////////////////////////////////////////////////////////////
  // status
  assign tx_fifo_empty = tx_wr_reg == tx_rd_reg;
  assign tx_fifo_full  = (tx_wr_reg[PTR_W] != tx_rd_reg[PTR_W])
                         && (tx_wr_reg[PTR_W-1:0] == tx_rd_reg[PTR_W-1:0]);
  assign rx_fifo_empty = rx_wr_reg == rx_rd_reg;
  assign rx_fifo_full  = (rx_wr_reg[PTR_W] != rx_rd_reg[PTR_W])
                         && (rx_wr_reg[PTR_W-1:0] == rx_rd_reg[PTR_W-1:0]);
  assign busy_flag     = (sh_state_reg != SH_IDLE) || !tx_fifo_empty;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign tx_push       = wr_fire && addr_is(aw_addr_reg, DATA_ADDR)
                         && !tx_fifo_full;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_data_reg  <= 32'h00000000;
      w_strb0_reg <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_strb0_reg <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (addr_is(aw_addr_reg, CONFIG_ADDR) || addr_is(aw_addr_reg, CONTROL_ADDR)
                       || addr_is(aw_addr_reg, DATA_ADDR) || addr_is(aw_addr_reg, STATUS_ADDR))
                      ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control and config registers; byte lane zero strobe gates every field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      loopback_select_reg      <= 1'b0;
      controller_enable_reg    <= 1'b0;
      role_select_reg          <= 1'b0;
      slave_output_disable_reg <= 1'b0;
      frame_size_field_reg     <= SIZE_RESET;
      clk_div_reg              <= DIV_RESET;
    end
    else if (wr_fire && w_strb0_reg)
    begin
      if (addr_is(aw_addr_reg, CONTROL_ADDR))
      begin
        loopback_select_reg      <= w_data_reg[CTL_LOOPBACK];
        controller_enable_reg    <= w_data_reg[CTL_ENABLE];
        slave_output_disable_reg <= w_data_reg[CTL_SOD];
        if (!controller_enable_reg)
        begin
          role_select_reg <= w_data_reg[CTL_ROLE];
        end
      end
      if (addr_is(aw_addr_reg, CONFIG_ADDR))
      begin
        frame_size_field_reg <= (w_data_reg[3:0] < SIZE_MIN_CODE) ? SIZE_MIN_CODE : w_data_reg[3:0];
        clk_div_reg          <= (w_data_reg[15:8] == 8'h00) ? 8'h01 : w_data_reg[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rx_pop        = rd_fire && addr_is(s_axi_araddr, DATA_ADDR) && !rx_fifo_empty;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (addr_is(s_axi_araddr, CONTROL_ADDR))
      begin
        s_axi_rdata[CTL_LOOPBACK] <= loopback_select_reg;
        s_axi_rdata[CTL_ENABLE]   <= controller_enable_reg;
        s_axi_rdata[CTL_ROLE]     <= role_select_reg;
        s_axi_rdata[CTL_SOD]      <= slave_output_disable_reg;
      end
      else if (addr_is(s_axi_araddr, CONFIG_ADDR))
      begin
        s_axi_rdata[3:0]  <= frame_size_field_reg;
        s_axi_rdata[15:8] <= clk_div_reg;
      end
      else if (addr_is(s_axi_araddr, DATA_ADDR))
      begin
        if (!rx_fifo_empty)
        begin
          s_axi_rdata[WORD_W-1:0] <= rx_mem[rx_rd_reg[PTR_W-1:0]];
        end
      end
      else if (addr_is(s_axi_araddr, STATUS_ADDR))
      begin
        s_axi_rdata[ST_TFE] <= tx_fifo_empty;
        s_axi_rdata[ST_TNF] <= !tx_fifo_full;
        s_axi_rdata[ST_RNE] <= !rx_fifo_empty;
        s_axi_rdata[ST_RFF] <= rx_fifo_full;
        s_axi_rdata[ST_BSY] <= busy_flag;
      end
      else
      begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wr_reg[PTR_W-1:0]] <= w_data_reg[WORD_W-1:0];
        tx_wr_reg <= ptr_inc(tx_wr_reg);
      end
      if (tx_pop)
      begin
        tx_rd_reg <= ptr_inc(tx_rd_reg);
      end
    end
  end

  // a received frame while full is dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
    end
    else
    begin
      if (frame_done && !rx_fifo_full)
      begin
        rx_mem[rx_wr_reg[PTR_W-1:0]] <= rx_shift_reg;
        rx_wr_reg <= ptr_inc(rx_wr_reg);
      end
      if (rx_pop)
      begin
        rx_rd_reg <= ptr_inc(rx_rd_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and serial datapath
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_sync_reg <= 3'b000;
      ssel_sync_reg <= 2'b11;
      mosi_sync_reg <= 2'b00;
      miso_sync_reg <= 2'b00;
      slv_sel_d_reg <= 1'b0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      ssel_sync_reg <= {ssel_sync_reg[0], ssel_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
      miso_sync_reg <= {miso_sync_reg[0], miso_in};
      slv_sel_d_reg <= slv_sel;
    end
  end

  assign frame_bits = {1'b0, frame_size_field_reg} + 5'd1;
  assign ser_out    = tx_shift_reg[WORD_W-1];
  assign ser_in     = loopback_select_reg ? ser_out
                      : (role_select_reg ? mosi_sync_reg[1] : miso_sync_reg[1]);
  assign slv_sel    = controller_enable_reg && role_select_reg && !ssel_sync_reg[1];
  // edges from second and third stage; needs clock at most aclk/12
  assign slv_rise   = sclk_sync_reg[2:1] == 2'b01;
  assign slv_fall   = sclk_sync_reg[2:1] == 2'b10;
  assign tick       = div_cnt_reg == 8'h00;
  assign tx_pop     = (sh_state_reg == SH_IDLE) && controller_enable_reg && !tx_fifo_empty
                      && (!role_select_reg || (slv_sel && !slv_sel_d_reg));
  assign frame_done = (sh_state_reg == SH_TRAIL) && (bit_cnt_reg == frame_bits)
                      && (role_select_reg ? 1'b1 : tick);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !controller_enable_reg)
    begin
      div_cnt_reg <= 8'h00;
    end
    else if (tick || sh_state_reg == SH_IDLE)
    begin
      // reload while idle so the first half-period is full length
      div_cnt_reg <= clk_div_reg - 8'h01;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !controller_enable_reg)
    begin
      sh_state_reg    <= SH_IDLE;
      tx_shift_reg    <= '0;
      rx_shift_reg    <= '0;
      bit_cnt_reg     <= 5'd0;
      master_sclk_reg <= 1'b0;
    end
    else
    begin
      unique case (sh_state_reg)
        SH_IDLE:
        begin
          master_sclk_reg <= 1'b0;
          if (tx_pop)
          begin
            tx_shift_reg <= tx_mem[tx_rd_reg[PTR_W-1:0]] << (5'd16 - frame_bits);
            rx_shift_reg <= '0;
            bit_cnt_reg  <= 5'd0;
            sh_state_reg <= SH_LEAD;
          end
        end
        SH_LEAD:
        begin
          if (role_select_reg ? slv_rise : tick)
          begin
            master_sclk_reg <= 1'b1;
            rx_shift_reg    <= {rx_shift_reg[WORD_W-2:0], ser_in};
            bit_cnt_reg     <= bit_cnt_reg + 5'd1;
            sh_state_reg    <= SH_TRAIL;
          end
          else if (role_select_reg && !slv_sel)
          begin
            sh_state_reg <= SH_IDLE;
          end
        end
        SH_TRAIL:
        begin
          if (frame_done)
          begin
            master_sclk_reg <= 1'b0;
            sh_state_reg    <= SH_IDLE;
          end
          else if (role_select_reg ? slv_fall : tick)
          begin
            master_sclk_reg <= 1'b0;
            tx_shift_reg    <= {tx_shift_reg[WORD_W-2:0], 1'b0};
            sh_state_reg    <= SH_LEAD;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  assign sclk_out   = master_sclk_reg;
  assign sclk_oe    = controller_enable_reg && !role_select_reg;
  assign ssel_n_out = sh_state_reg == SH_IDLE;
  assign ssel_n_oe  = controller_enable_reg && !role_select_reg;
  assign mosi_out   = ser_out;
  assign mosi_oe    = controller_enable_reg && !role_select_reg;
  assign miso_out   = ser_out;
  assign miso_oe    = controller_enable_reg && role_select_reg && slv_sel
                      && !slave_output_disable_reg;

endmodule

// file: hdl/spi_ctrl_pkg.sv
// Purpose: constants for the serial controller control, data and status block
// Assumes: 32-bit AXI4-Lite register bus, 10 MHz aclk
// Notes:   frame size and clock divider sit in a local config register
package spi_ctrl_pkg;
  localparam logic [31:0] CONFIG_ADDR      = 32'h40040000;
  localparam logic [31:0] CONTROL_ADDR     = 32'h40040004;
  localparam logic [31:0] DATA_ADDR        = 32'h40040008;
  localparam logic [31:0] STATUS_ADDR      = 32'h4004000C;
  localparam logic [11:0] ADDR_MASK        = 12'hFFF;
  localparam int          CTL_LOOPBACK     = 0;
  localparam int          CTL_ENABLE       = 1;
  localparam int          CTL_ROLE         = 2;
  localparam int          CTL_SOD          = 3;
  localparam int          ST_TFE           = 0;
  localparam int          ST_TNF           = 1;
  localparam int          ST_RNE           = 2;
  localparam int          ST_RFF           = 3;
  localparam int          ST_BSY           = 4;
  localparam int          FIFO_DEPTH       = 8;
  localparam int          PTR_W            = 3;
  localparam int          WORD_W           = 16;
  localparam logic [3:0]  SIZE_MIN_CODE    = 4'h3;
  localparam logic [3:0]  SIZE_RESET       = 4'h7;
  localparam logic [7:0]  DIV_RESET        = 8'h04;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;
  typedef enum logic [1:0] {SH_IDLE, SH_LEAD, SH_TRAIL} shift_state_t;
endpackage

// file: bench/spi_ctrl_monitor.sv
// Purpose: port-level checker for the serial controller block
// Assumes: config register left at its reset divider of four
// Notes:   attached by bind at the foot of this file
module spi_ctrl_monitor
  import spi_ctrl_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        ssel_n_in,
  input wire logic        ssel_n_out,
  input wire logic        ssel_n_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  sequence ssel_quiet;
    ssel_n_in [*4];
  endsequence
  sequence clk_high_run;
    sclk_out [*3];
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_master_pins: assert property (sclk_oe |-> mosi_oe && ssel_n_oe && !miso_oe)
    else $error("master pin drive wrong");
  chk_slave_pins: assert property (miso_oe |-> !sclk_oe && !mosi_oe && !ssel_n_oe)
    else $error("slave drives more than miso");
  chk_miso_unsel: assert property (ssel_quiet |-> !miso_oe)
    else $error("miso driven while not selected");
  chk_sclk_idle: assert property (sclk_oe && ssel_n_out |-> !sclk_out)
    else $error("serial clock high between frames");
  chk_sclk_half: assert property ($rose(sclk_out) |=> clk_high_run)
    else $error("serial clock half period short");
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !sclk_oe && !miso_oe)
    else $error("outputs active after reset");
endmodule

bind spi_ctrl_data_status spi_ctrl_monitor spi_ctrl_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ssel_n_in(ssel_n_in), .ssel_n_out(ssel_n_out),
  .ssel_n_oe(ssel_n_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe));

// file: bench/spi_peer_model.sv
// Purpose: behavioural serial slave facing the controller in master role
// Assumes: mode 0, eight-bit frames, msb first
// Notes:   reply byte is C0 plus frame count; miso flips when released
module spi_peer_model
(
  input  wire logic sclk,
  input  wire logic ssel_n,
  input  wire logic mosi,
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_sh    = 8'h00;
  logic [7:0] rx_sh    = 8'h00;
  logic [7:0] last_rx  = 8'h00;
  logic       in_frame = 1'b0;
  int         n_frames = 0;
  initial
    miso = 1'b0;
  always @(negedge ssel_n)
  begin
    in_frame = 1'b1;
    tx_sh = {4'hC, n_frames[3:0]};
    miso = tx_sh[7];
  end
  // sample on rising, shift on falling
  always @(posedge sclk)
    if (in_frame)
      rx_sh = {rx_sh[6:0], mosi};
  always @(negedge sclk)
    if (in_frame)
    begin
      tx_sh = {tx_sh[6:0], 1'b0};
      miso = tx_sh[7];
    end
  // released line shows the inverse of the last bit
  always @(posedge ssel_n)
    if (in_frame)
    begin
      in_frame = 1'b0;
      last_rx = rx_sh;
      n_frames++;
      miso = ~miso;
    end
endmodule

// file: bench/tb_top.sv
// Purpose: self-checking bench for the control, data and status block
// Assumes: 10 MHz aclk, reset divider and eight-bit frames
// Notes:   register table rows first, then frame, fill, slave and reset cases
module tb_top
  import spi_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic wr; logic [31:0] addr; logic [31:0] data; logic [1:0] resp;} row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic        sclk_out, sclk_oe, ssel_n_out, ssel_n_oe, mosi_out, mosi_oe, miso_out, miso_oe, peer_miso;
  logic        ssel_n_tb = 1'b1;
  int          n_errors = 0, num_checks = 0, cycles = 0, i;
  wire         sclk_w = (sclk_oe === 1'b1) ? sclk_out : 1'b0;
  wire         mosi_w = (mosi_oe === 1'b1) ? mosi_out : 1'b0;
  wire         ssel_w = (ssel_n_oe === 1'b1) ? ssel_n_out : ssel_n_tb;
  wire         miso_w = (miso_oe === 1'b1) ? miso_out : peer_miso;
  row_t rows [0:9] = '{
    '{1'b0, CONTROL_ADDR, 32'h0, RESP_OKAY}, '{1'b0, STATUS_ADDR, 32'h3, RESP_OKAY},
    '{1'b0, DATA_ADDR, 32'h0, RESP_OKAY}, '{1'b0, 32'h40040010, 32'h0, RESP_SLVERR},
    '{1'b1, 32'h40040014, 32'h1, RESP_SLVERR}, '{1'b1, CONTROL_ADDR, 32'h4, RESP_OKAY},
    '{1'b0, CONTROL_ADDR, 32'h4, RESP_OKAY}, '{1'b1, CONTROL_ADDR, 32'h2, RESP_OKAY},
    '{1'b1, CONTROL_ADDR, 32'h6, RESP_OKAY}, '{1'b0, CONTROL_ADDR, 32'h2, RESP_OKAY}};
  ////////////////////////////////////////////////////////////////
  spi_ctrl_data_status spi_ctrl_data_status_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .ssel_n_in(ssel_w), .ssel_n_out(ssel_n_out), .ssel_n_oe(ssel_n_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe));
  spi_peer_model spi_peer_model_i (.sclk(sclk_w), .ssel_n(ssel_w), .mosi(mosi_w), .miso(peer_miso));
  always #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_read(a, v, rs);
    check(nm, e, v);
  endtask
  task automatic wait_idle();
    logic [31:0] v;
    logic [1:0]  rs;
    do
      axi_read(STATUS_ADDR, v, rs);
    while (v[ST_BSY] !== 1'b0);
  endtask
  task stop_test();
    $display("mismatches %0d comparisons %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[k])
    begin
      if (rows[k].wr)
        axi_write(rows[k].addr, rows[k].data, r);
      else
        axi_read(rows[k].addr, d, r);
      check("resp", {30'h0, rows[k].resp}, {30'h0, r});
      if (!rows[k].wr && rows[k].resp == RESP_OKAY)
        check("rdata", rows[k].data, d);
    end
    // single frame in master role
    axi_write(DATA_ADDR, 32'hA5, r);
    for (i = 0; i < 20 && ssel_n_out !== 1'b0; i++)
      @(posedge aclk);
    check("select", 32'h0, {31'h0, ssel_n_out});
    check("master pins", 32'h7, {29'h0, sclk_oe, mosi_oe, ssel_n_oe});
    wait_idle();
    check("peer rx", 32'hA5, {24'h0, spi_peer_model_i.last_rx});
    rd_chk("rx data", DATA_ADDR, 32'hC0);
    // queued frames
    for (i = 1; i < 4; i++)
      axi_write(DATA_ADDR, 32'h11 * i, r);
    rd_chk("busy", STATUS_ADDR, 32'h12);
    wait_idle();
    check("peer last", 32'h33, {24'h0, spi_peer_model_i.last_rx});
    for (i = 1; i < 4; i++)
      rd_chk("rx order", DATA_ADDR, 32'hC0 + i);
    // fill while disabled, drain through loopback
    axi_write(CONTROL_ADDR, 32'h0, r);
    axi_write(CONTROL_ADDR, 32'h1, r);
    for (i = 0; i < 9; i++)
      axi_write(DATA_ADDR, 32'h11 * i, r);
    check("idle select", 32'h0, {31'h0, ssel_n_oe});
    rd_chk("tx full", STATUS_ADDR, 32'h10);
    axi_write(CONTROL_ADDR, 32'h3, r);
    wait_idle();
    rd_chk("rx full", STATUS_ADDR, 32'h0F);
    for (i = 0; i < 8; i++)
      rd_chk("loop rx", DATA_ADDR, 32'h11 * i);
    rd_chk("drained", STATUS_ADDR, 32'h03);
    // slave role pins
    axi_write(CONTROL_ADDR, 32'h0, r);
    axi_write(CONTROL_ADDR, 32'h4, r);
    axi_write(CONTROL_ADDR, 32'h6, r);
    ssel_n_tb <= 1'b0;
    repeat (4) @(posedge aclk);
    check("slave pins", 32'h8, {28'h0, miso_oe, sclk_oe, mosi_oe, ssel_n_oe});
    axi_write(CONTROL_ADDR, 32'hE, r);
    repeat (2) @(posedge aclk);
    check("miso off", 32'h0, {31'h0, miso_oe});
    ssel_n_tb <= 1'b1;
    // reset in mid-run with a queued word
    axi_write(CONTROL_ADDR, 32'h0, r);
    axi_write(DATA_ADDR, 32'h5, r);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("ctrl reset", CONTROL_ADDR, 32'h0);
    rd_chk("status reset", STATUS_ADDR, 32'h3);
    stop_test();
  end
endmodule
